// ### include/sgoc_pkg.sv
// Shared constants and types for the switchgear object control block
package sgoc_pkg;

  // ********
  // Timing
  // ********
  localparam int CLK_PERIOD_NS = 25;
  localparam int STEP_MS       = 20;
  localparam int STEP_CYC      = STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SET_W         = 15;
  localparam int CNT_W         = 32;
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 32;

  // ********
  // Register offsets
  // ********
  localparam logic [7:0] REG_CFG        = 8'h00;
  localparam logic [7:0] REG_TRAVERSE   = 8'h04;
  localparam logic [7:0] REG_CLOSE_MAX  = 8'h08;
  localparam logic [7:0] REG_OPEN_MAX   = 8'h0c;
  localparam logic [7:0] REG_TERM       = 8'h10;
  localparam logic [7:0] REG_FTRIP      = 8'h14;
  localparam logic [7:0] REG_CTRL       = 8'h18;
  localparam logic [7:0] REG_STATUS     = 8'h1c;
  localparam logic [7:0] REG_CNT_OPEN   = 8'h20;
  localparam logic [7:0] REG_CNT_CLOSE  = 8'h24;
  localparam logic [7:0] REG_CNT_OFAIL  = 8'h28;
  localparam logic [7:0] REG_CNT_CFAIL  = 8'h2c;
  localparam int         CTRL_CLR_BIT   = 0;

  // ********
  // Reset values and the continuous final-trip code, in 20 ms steps
  // ********
  localparam logic [SET_W-1:0] TRAV_DEF  = 15'h000a;
  localparam logic [SET_W-1:0] PULSE_DEF = 15'h000a;
  localparam logic [SET_W-1:0] TERM_DEF  = 15'h01f4;
  localparam logic [SET_W-1:0] FTRIP_DEF = 15'h000a;
  localparam logic [SET_W-1:0] FTRIP_CONT = 15'h0000;

  // ********
  // Counter indices
  // ********
  localparam int CI_OPEN  = 0;
  localparam int CI_CLOSE = 1;
  localparam int CI_OFAIL = 2;
  localparam int CI_CFAIL = 3;
  localparam int N_CNT    = 4;

  // ********
  // Types
  // ********
  typedef enum logic [1:0] {OBJ_WDCB = 2'h0, OBJ_CB = 2'h1, OBJ_DISC = 2'h2, OBJ_GND = 2'h3} sgoc_obj_t;
  typedef enum logic [1:0] {BRK_INTER = 2'h0, BRK_OPEN = 2'h1, BRK_CLOSED = 2'h2, BRK_BAD = 2'h3} sgoc_brk_t;
  typedef enum logic [2:0] {WD_INTER = 3'h0, WD_OUT = 3'h1, WD_IN = 3'h2, WD_BAD = 3'h3,
                            WD_UNUSED = 3'h4} sgoc_wd_t;
  typedef enum logic [1:0] {RDY_OFF = 2'h0, RDY_HIGH = 2'h1, RDY_LOW = 2'h2} sgoc_rdy_t;
  typedef enum logic [1:0] {LVL_USER = 2'h0, LVL_OPER = 2'h1, LVL_CONF = 2'h2, LVL_SUPER = 2'h3} sgoc_lvl_t;
  typedef enum logic [4:0] {ST_IDLE = 5'h01, ST_OPN_PULSE = 5'h02, ST_OPN_WAIT = 5'h04,
                            ST_CLS_PULSE = 5'h08, ST_CLS_WAIT = 5'h10} sgoc_state_t;

  typedef struct packed {
    sgoc_lvl_t level;
    sgoc_rdy_t rdy;
    logic      sync;
    sgoc_obj_t otype;
  } sgoc_cfg_t;

  localparam sgoc_cfg_t CFG_RST = '{level: LVL_CONF, rdy: RDY_OFF, sync: 1'b0, otype: OBJ_CB};

endpackage

// ### include/sgoc_tmr_if.sv
// Control bundle between one controlling block (sequencer, position monitor or final trip) and one step timer
`timescale 1ns/1ps
`default_nettype none
interface sgoc_tmr_if #(parameter int W = 15) ();
  logic         start;
  logic         stop;
  logic [W-1:0] load;
  logic         busy;
  logic         done;
  modport ctl (output start, stop, load, input busy, done);
  modport tmr (input start, stop, load, output busy, done);
endinterface
`default_nettype wire

// ### rtl/sgoc_timer.sv
// Down-counter of 20 ms steps with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module sgoc_timer #(
  parameter int W = 15
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic tick,
  sgoc_tmr_if.tmr   bus
);

  logic [W-1:0] cnt_r;
  logic         busy_r;
  logic         done_r;

  // Start beats stop, so a restart in the stop cycle is kept
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (bus.start) begin
        cnt_r  <= bus.load;
        busy_r <= 1'b1;
      end else if (bus.stop) begin
        busy_r <= 1'b0;
      end else if (busy_r && tick) begin
        if (cnt_r <= W'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

  assign bus.busy = busy_r;
  assign bus.done = done_r;

endmodule
`default_nettype wire

// ### rtl/sgoc_top.sv
// Switchgear object control: status monitoring, timed commands, statistics
// What this block does
// RULE1 - Withdrawable breaker: cart, position, checked control
// RULE2 - Fixed breaker: checked control, no cart monitoring
// RULE3 - Disconnector controlled; earthing switch indication only
// RULE4 - Open input high means object open
// RULE5 - Close input high means object closed
// RULE6 - Cart-in input high means racked in
// RULE7 - Cart-out input high means withdrawn
// RULE8 - Ready input high means spring charged
// RULE9 - Sync input high means closing permitted
// RULE10 - Commands are pulses on separate lines
// RULE11 - After traverse time, both active shows bad
// RULE12 - After traverse time, none active shows intermediate
// RULE13 - Close pulse capped, ends on closed
// RULE14 - Open pulse capped, ends on open
// RULE15 - No change before timeout: end, error
// RULE16 - Final-trip pulse of set length, zero continuous
// RULE17 - Under reclosing, final trip only on last
// RULE18 - Local, remote, application open/close requests
// RULE19 - Panel control needs minimum access level
// RULE20 - Sync check gates close when enabled
// RULE21 - Ready check gates close by polarity
// RULE22 - Blocking must arrive 5 ms early
// RULE23 - Four 32-bit request counters, clearable
// RULE24 - Refused request: no pulse, counted failed
// RULE25 - One command at a time, others ignored
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sgoc_top
  import sgoc_pkg::*;
#(
  parameter int TICK_CYC = STEP_CYC
) (
  input  wire logic              clock,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              pos_open_in,
  input  wire logic              pos_close_in,
  input  wire logic              cart_racked_in,
  input  wire logic              cart_withdrawn_in,
  input  wire logic              ready_in,
  input  wire logic              sync_ok_in,
  input  wire logic              loc_open_req,
  input  wire logic              loc_close_req,
  input  wire logic              rem_open_req,
  input  wire logic              rem_close_req,
  input  wire logic              app_open_req,
  input  wire logic              app_close_req,
  input  wire logic              panel_open_req,
  input  wire logic              panel_close_req,
  input  wire logic [1:0]        panel_level,
  input  wire logic              open_block_in,
  input  wire logic              close_block_in,
  input  wire logic              final_trip_in,
  input  wire logic              ar_control_in,
  input  wire logic              ar_last_shot_in,
  output logic                   open_cmd,
  output logic                   close_cmd,
  output logic                   final_trip_out,
  output logic                   cmd_err,
  output logic      [1:0]        brk_status,
  output logic      [2:0]        wd_status
);

  localparam int TW = $clog2(TICK_CYC);

  // ****************************************
  // Step tick
  // ****************************************
  logic [TW-1:0] tick_cnt_r;
  logic          tick;

  assign tick = (tick_cnt_r == TW'(TICK_CYC - 1));

  always_ff @(posedge clock) begin
    if (srst || tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  // ****************************************
  // Settings registers
  // ****************************************
  sgoc_cfg_t        cfg_r;
  logic [SET_W-1:0] trav_r;
  logic [SET_W-1:0] cls_max_r;
  logic [SET_W-1:0] opn_max_r;
  logic [SET_W-1:0] term_r;
  logic [SET_W-1:0] ftrip_r;
  logic             clr_stats;

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_r     <= CFG_RST;
      trav_r    <= TRAV_DEF;
      cls_max_r <= PULSE_DEF;
      opn_max_r <= PULSE_DEF;
      term_r    <= TERM_DEF;
      ftrip_r   <= FTRIP_DEF;
    end else if (wr_stb) begin
      unique case (addr)
        REG_CFG:       cfg_r     <= sgoc_cfg_t'(wdata[$bits(sgoc_cfg_t)-1:0]);
        REG_TRAVERSE:  trav_r    <= wdata[SET_W-1:0];
        REG_CLOSE_MAX: cls_max_r <= wdata[SET_W-1:0];
        REG_OPEN_MAX:  opn_max_r <= wdata[SET_W-1:0];
        REG_TERM:      term_r    <= wdata[SET_W-1:0];
        REG_FTRIP:     ftrip_r   <= wdata[SET_W-1:0];
        default:       ;
      endcase
    end
  end

  assign clr_stats = wr_stb && (addr == REG_CTRL) && wdata[CTRL_CLR_BIT];

  // ****************************************
  // Object kind
  // ****************************************
  logic is_brk;
  logic can_ctl;

  assign is_brk  = (cfg_r.otype == OBJ_WDCB) || (cfg_r.otype == OBJ_CB);  // RULE1 RULE2
  assign can_ctl = (cfg_r.otype != OBJ_GND);  // RULE3

  // ****************************************
  // Position monitoring
  // ****************************************
  sgoc_brk_t  raw_brk;
  sgoc_brk_t  brk_r;
  logic       raw_stable;
  logic       prev_stable_r;
  logic       trav_exp_r;
  sgoc_wd_t   wd_r;
  sgoc_tmr_if #(.W(SET_W)) trav_if ();

  always_comb begin
    unique case ({pos_close_in, pos_open_in})
      2'b01:   raw_brk = BRK_OPEN;    // RULE4
      2'b10:   raw_brk = BRK_CLOSED;  // RULE5
      2'b11:   raw_brk = BRK_BAD;
      default: raw_brk = BRK_INTER;
    endcase
  end

  assign raw_stable    = (raw_brk == BRK_OPEN) || (raw_brk == BRK_CLOSED);
  assign trav_if.start = !raw_stable && prev_stable_r;
  assign trav_if.stop  = raw_stable;
  assign trav_if.load  = trav_r;

  sgoc_timer #(.W(SET_W)) u_trav (
    .clock (clock),
    .srst  (srst),
    .tick  (tick),
    .bus   (trav_if.tmr)
  );

  // Last good position is held while the contacts travel
  always_ff @(posedge clock) begin
    if (srst) begin
      brk_r         <= BRK_INTER;
      prev_stable_r <= 1'b0;
      trav_exp_r    <= 1'b1;
    end else begin
      prev_stable_r <= raw_stable;
      if (raw_stable) begin
        trav_exp_r <= 1'b0;
      end else if (trav_if.done) begin
        trav_exp_r <= 1'b1;
      end
      if (raw_stable || trav_exp_r || trav_if.done) begin
        brk_r <= raw_brk;  // RULE11 RULE12
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wd_r <= WD_UNUSED;
    end else if (cfg_r.otype != OBJ_WDCB) begin
      wd_r <= WD_UNUSED;  // RULE2
    end else begin
      unique case ({cart_withdrawn_in, cart_racked_in})
        2'b01:   wd_r <= WD_IN;   // RULE6
        2'b10:   wd_r <= WD_OUT;  // RULE7
        2'b11:   wd_r <= WD_BAD;
        default: wd_r <= WD_INTER;
      endcase
    end
  end

  // ****************************************
  // Request sources
  // ****************************************
  logic panel_ok;
  logic opn_lvl;
  logic cls_lvl;
  logic opn_lvl_r;
  logic cls_lvl_r;
  logic opn_ev;
  logic cls_ev;

  assign panel_ok = (panel_level >= cfg_r.level);  // RULE19
  assign opn_lvl  = loc_open_req || rem_open_req || app_open_req || (panel_open_req && panel_ok);  // RULE18
  assign cls_lvl  = loc_close_req || rem_close_req || app_close_req || (panel_close_req && panel_ok);  // RULE18
  assign opn_ev   = opn_lvl && !opn_lvl_r;
  assign cls_ev   = cls_lvl && !cls_lvl_r;

  always_ff @(posedge clock) begin
    if (srst) begin
      opn_lvl_r <= 1'b0;
      cls_lvl_r <= 1'b0;
    end else begin
      opn_lvl_r <= opn_lvl;
      cls_lvl_r <= cls_lvl;
    end
  end

  // ****************************************
  // Close conditions
  // ****************************************
  logic rdy_ok;
  logic sync_ok;

  always_comb begin
    rdy_ok = 1'b1;
    if (is_brk && (cfg_r.rdy == RDY_HIGH)) begin
      rdy_ok = ready_in;  // RULE8 RULE21
    end else if (is_brk && (cfg_r.rdy == RDY_LOW)) begin
      rdy_ok = !ready_in;  // RULE21
    end
  end

  assign sync_ok = !is_brk || !cfg_r.sync || sync_ok_in;  // RULE9 RULE20

  // ****************************************
  // Command sequencer
  // ****************************************
  sgoc_state_t       state_r;
  sgoc_state_t       state_nxt;
  logic [N_CNT-1:0]  inc;
  logic              err_nxt;
  logic              at_open;
  logic              at_closed;
  sgoc_tmr_if #(.W(SET_W)) pulse_if ();
  sgoc_tmr_if #(.W(SET_W)) term_if ();

  assign at_open   = (raw_brk == BRK_OPEN);
  assign at_closed = (raw_brk == BRK_CLOSED);

  always_comb begin
    state_nxt      = state_r;
    inc            = '0;
    err_nxt        = 1'b0;
    pulse_if.start = 1'b0;
    pulse_if.stop  = 1'b0;
    pulse_if.load  = opn_max_r;
    term_if.start  = 1'b0;
    term_if.stop   = 1'b0;
    term_if.load   = term_r;
    unique case (state_r)
      ST_IDLE: begin
        // Open wins a tie; blocking is sampled at the request edge
        if (opn_ev && can_ctl) begin
          if (open_block_in) begin
            inc[CI_OFAIL] = 1'b1;  // RULE22 RULE24
          end else begin
            pulse_if.start = 1'b1;
            term_if.start  = 1'b1;
            state_nxt      = ST_OPN_PULSE;
          end
        end else if (cls_ev && can_ctl) begin
          pulse_if.load = cls_max_r;
          if (close_block_in || !rdy_ok || !sync_ok) begin
            inc[CI_CFAIL] = 1'b1;  // RULE24
          end else begin
            pulse_if.start = 1'b1;
            term_if.start  = 1'b1;
            state_nxt      = ST_CLS_PULSE;
          end
        end
      end
      ST_OPN_PULSE, ST_OPN_WAIT: begin
        if (at_open) begin
          inc[CI_OPEN]  = 1'b1;
          pulse_if.stop = 1'b1;  // RULE14
          term_if.stop  = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (term_if.done) begin
          inc[CI_OFAIL] = 1'b1;
          err_nxt       = 1'b1;  // RULE15
          pulse_if.stop = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (pulse_if.done) begin
          state_nxt = ST_OPN_WAIT;  // RULE14
        end
      end
      ST_CLS_PULSE, ST_CLS_WAIT: begin
        if (at_closed) begin
          inc[CI_CLOSE] = 1'b1;
          pulse_if.stop = 1'b1;  // RULE13
          term_if.stop  = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (term_if.done) begin
          inc[CI_CFAIL] = 1'b1;
          err_nxt       = 1'b1;  // RULE15
          pulse_if.stop = 1'b1;
          state_nxt     = ST_IDLE;
        end else if (pulse_if.done) begin
          state_nxt = ST_CLS_WAIT;  // RULE13
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  sgoc_timer #(.W(SET_W)) u_pulse (
    .clock (clock),
    .srst  (srst),
    .tick  (tick),
    .bus   (pulse_if.tmr)
  );

  sgoc_timer #(.W(SET_W)) u_term (
    .clock (clock),
    .srst  (srst),
    .tick  (tick),
    .bus   (term_if.tmr)
  );

  // New requests fall through idle-only decoding while busy
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_IDLE;
      cmd_err <= 1'b0;
    end else begin
      state_r <= state_nxt;  // RULE25
      cmd_err <= err_nxt;    // RULE15
    end
  end

  assign open_cmd  = (state_r == ST_OPN_PULSE);  // RULE10
  assign close_cmd = (state_r == ST_CLS_PULSE);  // RULE10

  // ****************************************
  // Final trip
  // ****************************************
  logic ftrip_lvl_r;
  logic ftrip_ev;
  logic ftrip_r_out;
  sgoc_tmr_if #(.W(SET_W)) ftrip_if ();

  assign ftrip_ev       = final_trip_in && !ftrip_lvl_r && (!ar_control_in || ar_last_shot_in);  // RULE17
  assign ftrip_if.start = ftrip_ev && (ftrip_r != FTRIP_CONT);
  assign ftrip_if.stop  = 1'b0;
  assign ftrip_if.load  = ftrip_r;

  sgoc_timer #(.W(SET_W)) u_ftrip (
    .clock (clock),
    .srst  (srst),
    .tick  (tick),
    .bus   (ftrip_if.tmr)
  );

  // Continuous mode holds until the next close command starts
  always_ff @(posedge clock) begin
    if (srst) begin
      ftrip_lvl_r <= 1'b0;
      ftrip_r_out <= 1'b0;
    end else begin
      ftrip_lvl_r <= final_trip_in;
      if (ftrip_ev) begin
        ftrip_r_out <= 1'b1;  // RULE16
      end else if (ftrip_if.done || (state_nxt == ST_CLS_PULSE && state_r == ST_IDLE)) begin
        ftrip_r_out <= 1'b0;  // RULE16
      end
    end
  end

  assign final_trip_out = ftrip_r_out;

  // ****************************************
  // Statistics
  // ****************************************
  logic [CNT_W-1:0] cnt_r [N_CNT];

  // Clear then count, so an event in the clear cycle survives
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < N_CNT; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CNT; i++) begin
        cnt_r[i] <= (clr_stats ? '0 : cnt_r[i]) + CNT_W'(inc[i]);  // RULE23
      end
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [10:0] stat_word;

  assign stat_word = {sync_ok_in, ready_in, ftrip_r_out, close_cmd, open_cmd,
                      (state_r != ST_IDLE), wd_r, brk_r};

  always_ff @(posedge clock) begin
    if (srst || !rd_stb) begin
      rdata <= '0;
    end else begin
      unique case (addr)
        REG_CFG:       rdata <= DATA_W'(cfg_r);
        REG_TRAVERSE:  rdata <= DATA_W'(trav_r);
        REG_CLOSE_MAX: rdata <= DATA_W'(cls_max_r);
        REG_OPEN_MAX:  rdata <= DATA_W'(opn_max_r);
        REG_TERM:      rdata <= DATA_W'(term_r);
        REG_FTRIP:     rdata <= DATA_W'(ftrip_r);
        REG_STATUS:    rdata <= DATA_W'(stat_word);
        REG_CNT_OPEN:  rdata <= cnt_r[CI_OPEN];
        REG_CNT_CLOSE: rdata <= cnt_r[CI_CLOSE];
        REG_CNT_OFAIL: rdata <= cnt_r[CI_OFAIL];
        REG_CNT_CFAIL: rdata <= cnt_r[CI_CFAIL];
        default:       rdata <= '0;
      endcase
    end
  end

  assign brk_status = brk_r;
  assign wd_status  = wd_r;

endmodule
`default_nettype wire

// ### sim/sgoc_checker.sv
// Port-level assertions for the switchgear object control block
`timescale 1ns/1ps
`default_nettype none
module sgoc_checker
  import sgoc_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       pos_open_in,
  input wire logic       pos_close_in,
  input wire logic       open_block_in,
  input wire logic       close_block_in,
  input wire logic       final_trip_in,
  input wire logic       ar_control_in,
  input wire logic       ar_last_shot_in,
  input wire logic       open_cmd,
  input wire logic       close_cmd,
  input wire logic       final_trip_out,
  input wire logic       cmd_err,
  input wire logic [1:0] brk_status
);
  // ********
  // Pulse length counter
  // ********
  // Valid only with pulse maxima up to the default
  localparam int PMAX = 10 * TICK_CYC + 2;
  logic [15:0] plen_r;
  always_ff @(posedge clock) begin
    if (srst || !(open_cmd || close_cmd)) plen_r <= 16'h0000;
    else plen_r <= plen_r + 16'h0001;
  end

  // ********
  // Properties
  // ********
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_open_done; open_cmd && pos_open_in && !pos_close_in; endsequence
  sequence s_close_done; close_cmd && pos_close_in && !pos_open_in; endsequence
  sequence s_ft_req; $rose(final_trip_in) && (!ar_control_in || ar_last_shot_in); endsequence
  property p_one_cmd; !(open_cmd && close_cmd); endproperty
  property p_open_free; $rose(open_cmd) |-> !$past(open_block_in); endproperty
  property p_close_free; $rose(close_cmd) |-> !$past(close_block_in); endproperty
  property p_open_end; s_open_done |=> !open_cmd; endproperty
  property p_close_end; s_close_done |=> !close_cmd; endproperty
  property p_pulse_max; plen_r <= PMAX; endproperty
  property p_open_shown; pos_open_in && !pos_close_in |=> brk_status == BRK_OPEN; endproperty
  property p_closed_shown; pos_close_in && !pos_open_in |=> brk_status == BRK_CLOSED; endproperty
  property p_err_end; cmd_err |-> !open_cmd && !close_cmd ##1 !cmd_err; endproperty
  property p_ft_on; s_ft_req |=> final_trip_out; endproperty
  property p_ft_gate;
    $rose(final_trip_out) |-> $past(final_trip_in) && ($past(ar_control_in) == 1'b0 || $past(ar_last_shot_in));
  endproperty
  a_one_cmd: assert property (p_one_cmd)
    else $error("open and close pulses together");
  a_open_free: assert property (p_open_free)
    else $error("blocked open pulsed");
  a_close_free: assert property (p_close_free)
    else $error("blocked close pulsed");
  a_open_end: assert property (p_open_end)
    else $error("open pulse overran");
  a_close_end: assert property (p_close_end)
    else $error("close pulse overran");
  a_pulse_max: assert property (p_pulse_max)
    else $error("command pulse too long");
  a_open_shown: assert property (p_open_shown)
    else $error("open position not shown");
  a_closed_shown: assert property (p_closed_shown)
    else $error("closed position not shown");
  a_err_end: assert property (p_err_end)
    else $error("bad timeout error");
  a_ft_on: assert property (p_ft_on)
    else $error("final trip output missing");
  a_ft_gate: assert property (p_ft_gate)
    else $error("final trip without cause");
endmodule

bind sgoc_top sgoc_checker #(.TICK_CYC(TICK_CYC)) i_chk (
  .clock(clock), .srst(srst), .pos_open_in(pos_open_in), .pos_close_in(pos_close_in),
  .open_block_in(open_block_in), .close_block_in(close_block_in), .final_trip_in(final_trip_in),
  .ar_control_in(ar_control_in), .ar_last_shot_in(ar_last_shot_in), .open_cmd(open_cmd),
  .close_cmd(close_cmd), .final_trip_out(final_trip_out), .cmd_err(cmd_err), .brk_status(brk_status)
);
`default_nettype wire

// ### sim/sgoc_brk_model.sv
// Behavioural breaker: auxiliary contacts answering command pulses
`timescale 1ns/1ps
`default_nettype none
module sgoc_brk_model #(
  parameter int DLY = 3
) (
  input  wire logic       clock,
  input  wire logic       open_cmd,
  input  wire logic       close_cmd,
  input  wire logic [1:0] mode,
  output logic            pos_open_in,
  output logic            pos_close_in
);
  // Mode 0 normal, 1 stuck mechanism, 2 both contacts made, 3 none made
  logic       is_open_r = 1'b0;
  logic [3:0] cnt_r     = 4'h0;
  always @(posedge clock) begin
    if ((open_cmd || close_cmd) && mode != 2'h1) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'(DLY)) is_open_r <= open_cmd;
    end else cnt_r <= 4'h0;
  end
  assign pos_open_in  = (mode == 2'h2) || (mode != 2'h3 && is_open_r);
  assign pos_close_in = (mode == 2'h2) || (mode != 2'h3 && !is_open_r);
endmodule
`default_nettype wire

// ### sim/tb_sgoc_top.sv
// Self-checking bench for the switchgear object control block
`timescale 1ns/1ps
`default_nettype none
module tb_sgoc_top;
  import sgoc_pkg::*;
  localparam int TK = 4;
  logic              clock = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [8:0]        reqs = 9'h000;
  logic [1:0]        panel_level = 2'h0, mode = 2'h0, cart = 2'h0, brk_status;
  logic              ready_in = 1'b0, sync_ok_in = 1'b0, open_block_in = 1'b0, close_block_in = 1'b0;
  logic              ar_control_in = 1'b0, ar_last_shot_in = 1'b0;
  logic              pos_open_in, pos_close_in, open_cmd, close_cmd, final_trip_out, cmd_err;
  logic [2:0]        wd_status;
  logic [31:0]       exp_q[$];
  logic [31:0]       dflt[5] = '{32'ha, 32'ha, 32'ha, 32'h1f4, 32'ha};
  int                num_errors = 0, checks_done = 0, t;

  always #12.5 clock = ~clock;

  sgoc_top #(.TICK_CYC(TK)) i_dut (
    .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pos_open_in(pos_open_in), .pos_close_in(pos_close_in), .cart_racked_in(cart[0]),
    .cart_withdrawn_in(cart[1]), .ready_in(ready_in), .sync_ok_in(sync_ok_in),
    .loc_open_req(reqs[0]), .loc_close_req(reqs[1]), .rem_open_req(reqs[2]), .rem_close_req(reqs[3]),
    .app_open_req(reqs[4]), .app_close_req(reqs[5]), .panel_open_req(reqs[6]), .panel_close_req(reqs[7]),
    .panel_level(panel_level), .open_block_in(open_block_in), .close_block_in(close_block_in),
    .final_trip_in(reqs[8]), .ar_control_in(ar_control_in), .ar_last_shot_in(ar_last_shot_in),
    .open_cmd(open_cmd), .close_cmd(close_cmd), .final_trip_out(final_trip_out), .cmd_err(cmd_err),
    .brk_status(brk_status), .wd_status(wd_status)
  );
  sgoc_brk_model #(.DLY(3)) i_brk (
    .clock(clock), .open_cmd(open_cmd), .close_cmd(close_cmd), .mode(mode),
    .pos_open_in(pos_open_in), .pos_close_in(pos_close_in)
  );

  // ********
  // Bus, request and compare tasks
  // ********
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    rd_stb <= 1'b0;
  endtask
  // Contacts of the cart change at random: a fixed breaker must ignore them
  task automatic rq(input int b);
    @(posedge clock);
    reqs[b] <= 1'b1;
    cart <= 2'($urandom);
    @(posedge clock);
    reqs[b] <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic wait_for(input int w);
    for (int i = 0; i < 500; i++) begin
      @(negedge clock);
      if ((w == 0 && (open_cmd | close_cmd) === 1'b0) || (w == 1 && cmd_err === 1'b1)
          || (w == 2 && final_trip_out === 1'b0)) break;
    end
  endtask
  function automatic logic [31:0] stw(input logic [1:0] b, input logic f);
    return {21'h0, sync_ok_in, ready_in, f, 3'h0, 3'h4, b};
  endfunction
  task automatic cmp_rd(input logic [31:0] e);
    checks_done++;
    if (rdata !== e) begin
      num_errors++;
      $display("Error at %0t: read %h, expected %h", $time, rdata, e);
    end
  endtask
  task automatic end_of_test();
    $display("Errors: %0d, checks: %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ********
  // Read result monitor
  // ********
  always @(posedge clock) begin
    if (rd_d) cmp_rd(exp_q.pop_front());
    rd_d <= rd_stb;
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    void'($urandom(34));
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    rd(REG_CFG, 32'h41);
    foreach (dflt[i]) rd(8'h04 + 8'(4 * i), dflt[i]);
    rd(8'h30, 32'h0);
    rq(4);
    wait_for(0);
    rd(REG_CNT_OPEN, 32'h1);
    rd(REG_STATUS, stw(2'h1, 1'b0));
    wr(REG_CFG, 32'h49);
    rq(1);
    rd(REG_CNT_CFAIL, 32'h1);
    wr(REG_CFG, 32'h4d);
    ready_in <= 1'b1;
    rq(3);
    rd(REG_CNT_CFAIL, 32'h2);
    sync_ok_in <= 1'b1;
    rq(5);
    wait_for(0);
    rd(REG_CNT_CLOSE, 32'h1);
    rd(REG_STATUS, stw(2'h2, 1'b0));
    open_block_in <= 1'b1;
    close_block_in <= 1'b1;
    rq(0);
    rq(1);
    open_block_in <= 1'b0;
    close_block_in <= 1'b0;
    rd(REG_CNT_OFAIL, 32'h1);
    rd(REG_CNT_CFAIL, 32'h3);
    wr(REG_TERM, 32'h14);
    mode <= 2'h1;
    rq(2);
    rq(1);
    wait_for(1);
    mode <= 2'h0;
    rd(REG_CNT_OFAIL, 32'h2);
    rd(REG_CNT_CFAIL, 32'h3);
    rq(6);
    rd(REG_CNT_OPEN, 32'h1);
    panel_level <= 2'h3;
    rq(6);
    wait_for(0);
    rd(REG_CNT_OPEN, 32'h2);
    ar_control_in <= 1'b1;
    rq(8);
    rd(REG_STATUS, stw(2'h1, 1'b0));
    ar_last_shot_in <= 1'b1;
    rq(8);
    rd(REG_STATUS, stw(2'h1, 1'b1));
    wait_for(2);
    wr(REG_FTRIP, 32'h0);
    rq(8);
    repeat (15 * TK) @(posedge clock);
    rd(REG_STATUS, stw(2'h1, 1'b1));
    rq(5);
    wait_for(0);
    rd(REG_STATUS, stw(2'h2, 1'b0));
    t = 3 + ($urandom % 8);
    wr(REG_TRAVERSE, 32'(t));
    rd(REG_TRAVERSE, 32'(t));
    mode <= 2'h2;
    rd(REG_STATUS, stw(2'h2, 1'b0));
    repeat ((t + 1) * TK) @(posedge clock);
    rd(REG_STATUS, stw(2'h3, 1'b0));
    mode <= 2'h3;
    rd(REG_STATUS, stw(2'h0, 1'b0));
    mode <= 2'h0;
    wr(REG_CFG, 32'h48);
    cart <= 2'h1;
    rd(REG_STATUS, stw(2'h2, 1'b0) ^ 32'h18);
    cart <= 2'h2;
    rd(REG_STATUS, stw(2'h2, 1'b0) ^ 32'h14);
    wr(REG_CFG, 32'h4f);
    rq(4);
    rd(REG_CNT_OPEN, 32'h2);
    rd(REG_CNT_OFAIL, 32'h2);
    wr(REG_CTRL, 32'h1);
    for (int i = 0; i < N_CNT; i++) rd(REG_CNT_OPEN + 8'(4 * i), 32'h0);
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule
`default_nettype wire
